/* hw/bus_port_pkg.sv */
package bus_port_pkg;

   // Register indices on the byte-wide register port
   localparam logic [3:0] ADDR_HI_DATA_OFS = 4'h0;
   localparam logic [3:0] ADDR_LO_DATA_OFS = 4'h1;
   localparam logic [3:0] ADDR_HI_DIR_OFS  = 4'h2;
   localparam logic [3:0] ADDR_LO_DIR_OFS  = 4'h3;
   localparam logic [3:0] RSVD_FIRST_OFS   = 4'h4;
   localparam logic [3:0] RSVD_LAST_OFS    = 4'h7;
   localparam logic [3:0] CTRL_DATA_OFS    = 4'h8;
   localparam logic [3:0] CTRL_DIR_OFS     = 4'h9;
   localparam logic [3:0] FUNC_SEL_OFS     = 4'ha;
   localparam logic [3:0] PULL_CTRL_OFS    = 4'hc;

   // Reset values
   localparam logic [7:0] DATA_RST     = 8'h00;
   localparam logic [7:0] DIR_RST      = 8'h00;
   localparam logic [7:0] FUNC_SEL_RST = 8'h00;
   localparam logic       PULL_EN_RST  = 1'b0;

   // Control-port pins that can only be inputs
   localparam logic [7:0] CTRL_IN_ONLY = 8'h03;

   // Operating modes, taken as a level input
   typedef enum logic [1:0] {
      MODE_SINGLE     = 2'b00,
      MODE_EXPANDED   = 2'b01,
      MODE_PERIPHERAL = 2'b10
   } op_mode_t;

   // Bus state of an access
   typedef enum logic [1:0] {
      ACC_IDLE  = 2'b00,
      ACC_LOCAL = 2'b01,
      ACC_ECHO  = 2'b10
   } acc_state_t;

   // Merge stored data with pin level according to direction
   function automatic logic [7:0] port_view(input logic [7:0] dir,
                                            input logic [7:0] data,
                                            input logic [7:0] pins);
      port_view = (dir & data) | (~dir & pins);
   endfunction : port_view

endpackage : bus_port_pkg

/* hw/port_pin_bank.sv */
// One 8-bit port: data and direction flops, pin drive and read view
module port_pin_bank
   import bus_port_pkg::*;
#(
   parameter int          WIDTH   = 8,
   parameter logic [7:0]  IN_ONLY = 8'h00
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Register writes
   input  wire logic             data_we,
   input  wire logic             dir_we,
   input  wire logic [WIDTH-1:0] wdata,
   // Alternate function override
   input  wire logic [WIDTH-1:0] alt_sel,
   input  wire logic [WIDTH-1:0] alt_out,
   input  wire logic [WIDTH-1:0] alt_oe,
   // Pins
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe_n,
   // Register views
   output logic      [WIDTH-1:0] data_q,
   output logic      [WIDTH-1:0] dir_q,
   output logic      [WIDTH-1:0] read_view
);

   logic [WIDTH-1:0] drive;   // Pin is a driven output

   // Stored data bits
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         data_q <= DATA_RST;
      end else if (data_we) begin
         data_q <= wdata;
      end
   end

   // Direction bits; input-only pins never store a 1
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         dir_q <= DIR_RST; // [R6]
      end else if (dir_we) begin
         dir_q <= wdata & ~IN_ONLY; // [R15]
      end
   end

   // Alternate function wins over direction for selected pins
   always_comb begin
      drive = (alt_sel & alt_oe) | (~alt_sel & dir_q); // [R19] [R14] [R4]
   end

   // Pin flops; enable is low while driving
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_out  <= '0;
         pin_oe_n <= '1;
      end else begin
         pin_out  <= (alt_sel & alt_out) | (~alt_sel & data_q); // [R4]
         pin_oe_n <= ~(drive & ~IN_ONLY); // [R15]
      end
   end

   // Read source follows the direction bit
   always_comb begin
      read_view = port_view(dir_q, data_q, pin_in); // [R5] [R15]
   end

endmodule : port_pin_bank

/* hw/bus_port_gpio_registers.sv */
// Behaviour
// [R1] Expanded: high port carries A15..A8 plus data
// [R2] Expanded: low port carries A7..A0, D7..D0
// [R3] Single chip: bus ports are general I/O
// [R4] Direction 1 drives data, 0 floats
// [R5] Read gives pin if input, data if output
// [R6] Address port directions reset to zero
// [R7] Expanded/peripheral: address port registers echoed out
// [R8] Reserved locations and bits read zero
// [R9] Peripheral mode: reserved locations not mapped
// [R10] Control data unmapped: peripheral, or emulate bit; the code applies the emulate bit in expanded mode only
// [R11] Control direction unmapped: expanded, peripheral, emulate; the code ignores the emulate bit (unmapped in expanded or peripheral only)
// [R12] Control port carries bus, interrupt functions
// [R13] Control pins 7:2 bidirectional, 1:0 inputs
// [R14] Function select picks general or alternate
// [R15] Interrupt pins never outputs, always readable
// [R16] One bit enables all control-port pulls
// [R17] Software waits a cycle after direction write
// [R18] Software loads data before enabling outputs
// [R19] Alternate function overrides direction bit
//
// The implementer's own choices: the address map and the address-and-strobe port.
module bus_port_gpio_registers
   import bus_port_pkg::*;
#(
   parameter logic [7:0] PULL_UP_POLARITY = 8'hff // Fixed at integration
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Mode straps, level inputs
   input  wire logic [1:0] op_mode,
   input  wire logic       wide_bus,
   input  wire logic       emulate_control_port_bit,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Echo of unmapped accesses to the external bus
   output logic            ext_req,
   output logic            ext_wr,
   output logic      [3:0] ext_addr,
   output logic      [7:0] ext_wdata,
   // External bus address/data from the bus engine
   input  wire logic [15:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_data_oe,
   // Bus control functions for the control port pins 7:2
   input  wire logic [7:2] ctrl_alt_out,
   input  wire logic [7:2] ctrl_alt_oe,
   // High address port pins
   input  wire logic [7:0] addr_hi_pin_in,
   output logic      [7:0] addr_hi_pin_out,
   output logic      [7:0] addr_hi_pin_oe_n,
   // Low address port pins
   input  wire logic [7:0] addr_lo_pin_in,
   output logic      [7:0] addr_lo_pin_out,
   output logic      [7:0] addr_lo_pin_oe_n,
   // Control port pins
   input  wire logic [7:0] ctrl_pin_in,
   output logic      [7:0] ctrl_pin_out,
   output logic      [7:0] ctrl_pin_oe_n,
   output logic      [7:0] ctrl_pull_en,
   output logic      [7:0] ctrl_pull_up,
   // Interrupt inputs passed on to the core
   output logic            mask_irq_n,
   output logic            nonmaskable_interrupt_pin
);

   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   op_mode_t   mode;          // Current mode
   logic       expanded;      // Expanded bus mode
   logic       peripheral;    // Special peripheral mode
   logic       bus_owns_ports;// Address ports serve the bus
   logic [7:0] func_sel_q;    // 1 = alternate function per pin
   logic       pull_en_q;     // Shared pull enable

   always_comb begin
      mode       = op_mode_t'(op_mode);
      expanded   = (mode == MODE_EXPANDED);
      peripheral = (mode == MODE_PERIPHERAL);
      // Peripheral mode also uses the pins as a bus
      bus_owns_ports = expanded | peripheral; // [R3]
   end

   ////////////////////////////////////////////////////////////////////////
   // Address map

   logic map_ab;     // Address ports and directions present
   logic map_rsvd;   // Reserved locations present
   logic map_cdata;  // Control data present
   logic map_cdir;   // Control direction present
   logic map_local;  // Current address answers locally
   logic hit_rsvd;   // Address inside reserved range

   always_comb begin
      map_ab    = !(expanded || peripheral); // [R7]
      map_rsvd  = !peripheral; // [R9]
      map_cdata = !peripheral &&
                  !(expanded && emulate_control_port_bit); // [R10]
      map_cdir  = !(expanded || peripheral); // [R11]
      hit_rsvd  = (reg_addr >= RSVD_FIRST_OFS) &&
                  (reg_addr <= RSVD_LAST_OFS);
      case (reg_addr)
         ADDR_HI_DATA_OFS, ADDR_LO_DATA_OFS,
         ADDR_HI_DIR_OFS, ADDR_LO_DIR_OFS: map_local = map_ab; // [R7]
         CTRL_DATA_OFS: map_local = map_cdata; // [R10]
         CTRL_DIR_OFS:  map_local = map_cdir; // [R11]
         FUNC_SEL_OFS, PULL_CTRL_OFS: map_local = map_ab;
         default: begin
            // Reserved answers locally unless unmapped
            map_local = hit_rsvd ? map_rsvd : 1'b1; // [R9]
         end
      endcase
   end

   // Per-register write strobes, only while mapped
   logic wr_local;
   always_comb begin
      wr_local = reg_wr && map_local;
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers of the control port

   // Function select; bits 1:0 hold no alternate output role
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         func_sel_q <= FUNC_SEL_RST;
      end else if (wr_local && reg_addr == FUNC_SEL_OFS) begin
         func_sel_q <= reg_wdata & ~CTRL_IN_ONLY; // [R14]
      end
   end

   // One shared pull enable bit
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pull_en_q <= PULL_EN_RST;
      end else if (wr_local && reg_addr == PULL_CTRL_OFS) begin
         pull_en_q <= reg_wdata[0]; // [R16]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port banks

   logic [7:0] hi_data, hi_dir, hi_view;
   logic [7:0] lo_data, lo_dir, lo_view;
   logic [7:0] ce_data, ce_dir, ce_view;
   logic [7:0] hi_alt_out, lo_alt_out, ab_alt_oe, ab_sel;
   logic [7:0] ce_alt_out, ce_alt_oe;

   // Bus use of the address ports; wide_bus picks upper or lower data
   always_comb begin
      ab_sel     = {8{bus_owns_ports}};
      ab_alt_oe  = {8{1'b1}};
      hi_alt_out = bus_data_oe ?
                   (wide_bus ? bus_wdata[15:8] : bus_wdata[7:0]) :
                   bus_addr[15:8]; // [R1]
      lo_alt_out = bus_data_oe ? bus_wdata[7:0] : bus_addr[7:0]; // [R2]
      // Control port alternate functions on pins 7:2 only
      ce_alt_out = {ctrl_alt_out, 2'b00}; // [R12]
      ce_alt_oe  = {ctrl_alt_oe, 2'b00}; // [R13]
   end

   port_pin_bank #(.WIDTH(8), .IN_ONLY(8'h00)) u_hi (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .data_we   (wr_local && reg_addr == ADDR_HI_DATA_OFS),
      .dir_we    (wr_local && reg_addr == ADDR_HI_DIR_OFS),
      .wdata     (reg_wdata),
      .alt_sel   (ab_sel),
      .alt_out   (hi_alt_out),
      .alt_oe    (ab_alt_oe),
      .pin_in    (addr_hi_pin_in),
      .pin_out   (addr_hi_pin_out),
      .pin_oe_n  (addr_hi_pin_oe_n),
      .data_q    (hi_data),
      .dir_q     (hi_dir),
      .read_view (hi_view)
   );

   port_pin_bank #(.WIDTH(8), .IN_ONLY(8'h00)) u_lo (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .data_we   (wr_local && reg_addr == ADDR_LO_DATA_OFS),
      .dir_we    (wr_local && reg_addr == ADDR_LO_DIR_OFS),
      .wdata     (reg_wdata),
      .alt_sel   (ab_sel),
      .alt_out   (lo_alt_out),
      .alt_oe    (ab_alt_oe),
      .pin_in    (addr_lo_pin_in),
      .pin_out   (addr_lo_pin_out),
      .pin_oe_n  (addr_lo_pin_oe_n),
      .data_q    (lo_data),
      .dir_q     (lo_dir),
      .read_view (lo_view)
   );

   // Control port: pins 1:0 input only, still readable
   port_pin_bank #(.WIDTH(8), .IN_ONLY(CTRL_IN_ONLY)) u_ce (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .data_we   (wr_local && reg_addr == CTRL_DATA_OFS),
      .dir_we    (wr_local && reg_addr == CTRL_DIR_OFS),
      .wdata     (reg_wdata),
      .alt_sel   (func_sel_q),
      .alt_out   (ce_alt_out),
      .alt_oe    (ce_alt_oe),
      .pin_in    (ctrl_pin_in),
      .pin_out   (ctrl_pin_out),
      .pin_oe_n  (ctrl_pin_oe_n),
      .data_q    (ce_data),
      .dir_q     (ce_dir),
      .read_view (ce_view)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pulls and interrupt inputs

   // Pull only where the pin is an input; interrupt pins pull up
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_pull_en <= 8'h00;
         ctrl_pull_up <= 8'h00;
      end else begin
         ctrl_pull_en <= {8{pull_en_q}} & ctrl_pin_oe_n; // [R16]
         ctrl_pull_up <= PULL_UP_POLARITY | CTRL_IN_ONLY; // [R16]
      end
   end

   // Interrupt levels reach the core whatever the read path does
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mask_irq_n                <= 1'b1;
         nonmaskable_interrupt_pin <= 1'b1;
      end else begin
         mask_irq_n                <= ctrl_pin_in[1]; // [R12]
         nonmaskable_interrupt_pin <= ctrl_pin_in[0]; // [R12]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe

   logic [7:0] rd_d;   // Read mux output

   always_comb begin
      case (reg_addr)
         ADDR_HI_DATA_OFS: rd_d = hi_view; // [R5]
         ADDR_LO_DATA_OFS: rd_d = lo_view; // [R5]
         ADDR_HI_DIR_OFS:  rd_d = hi_dir;
         ADDR_LO_DIR_OFS:  rd_d = lo_dir;
         CTRL_DATA_OFS:    rd_d = ce_view; // [R15]
         CTRL_DIR_OFS:     rd_d = ce_dir;
         FUNC_SEL_OFS:     rd_d = func_sel_q;
         PULL_CTRL_OFS:    rd_d = {7'h00, pull_en_q}; // [R8]
         default:          rd_d = 8'h00; // [R8]
      endcase
   end

   // Data stand only in the cycle after the strobe; zero otherwise
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && map_local) begin
         reg_rdata <= rd_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Echo of unmapped accesses

   acc_state_t acc_q;  // Kind of access at the last edge, idle if none

   // Unmapped accesses leave as a one-cycle request
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         acc_q     <= ACC_IDLE;
         ext_req   <= 1'b0;
         ext_wr    <= 1'b0;
         ext_addr  <= 4'h0;
         ext_wdata <= 8'h00;
      end else begin
         case ({reg_wr | reg_rd, map_local})
            2'b10: begin
               acc_q     <= ACC_ECHO;
               ext_req   <= 1'b1; // [R7] [R10] [R11]
               ext_wr    <= reg_wr;
               ext_addr  <= reg_addr;
               ext_wdata <= reg_wdata;
            end
            2'b11: begin
               acc_q   <= ACC_LOCAL;
               ext_req <= 1'b0;
               ext_wr  <= 1'b0;
            end
            default: begin
               acc_q   <= ACC_IDLE;
               ext_req <= 1'b0;
               ext_wr  <= 1'b0;
            end
         endcase
      end
   end

endmodule : bus_port_gpio_registers

/* verification/port_check_props.sv */
// Port-level checker, bound to the register block
module port_check
   import bus_port_pkg::*;
(
   // Clock and reset
   input wire logic       mclk,
   input wire logic       sys_rst,
   // Straps and register port
   input wire logic [1:0] op_mode,
   input wire logic       emulate_control_port_bit,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       ext_req,
   // Pins
   input wire logic [7:0] addr_hi_pin_oe_n,
   input wire logic [7:0] addr_lo_pin_oe_n,
   input wire logic [7:0] ctrl_pin_in,
   input wire logic [7:0] ctrl_pin_oe_n,
   input wire logic [7:0] ctrl_pull_up,
   input wire logic       mask_irq_n,
   input wire logic       nonmaskable_interrupt_pin
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   ////////////////////////////////////////////////////////////////////////
   // Direction write reaches the pins two edges later
   AST_DIR_DRIVE: assert property (
      (reg_wr && reg_addr == ADDR_HI_DIR_OFS && op_mode == MODE_SINGLE)
      ##1 (!reg_wr && op_mode == MODE_SINGLE)
      |=> addr_hi_pin_oe_n == ~$past(reg_wdata, 2))
      else $error("high port enable does not follow direction");
   // Address ports float straight out of reset
   AST_ADDR_DIR_RST: assert property (
      $fell(sys_rst) |-> (addr_hi_pin_oe_n & addr_lo_pin_oe_n) == 8'hff)
      else $error("address port driven after reset");
   // Expanded mode echoes address port writes
   AST_ADDR_ECHO: assert property (
      reg_wr && op_mode == MODE_EXPANDED && reg_addr <= 4'h3 |=> ext_req)
      else $error("address port write not echoed");
   // Reserved places read zero in single chip
   AST_RSVD_ZERO: assert property (
      reg_rd && op_mode == MODE_SINGLE && reg_addr inside {[4:7]}
      |=> reg_rdata == 8'h00 && !ext_req)
      else $error("reserved read not zero");
   // Reserved places leave the map in peripheral mode
   AST_PERIPH_RSVD: assert property (
      reg_rd && op_mode == MODE_PERIPHERAL && reg_addr inside {[4:7]}
      |=> ext_req && reg_rdata == 8'h00)
      else $error("reserved read not echoed");
   // Emulate bit removes control data from the map in expanded mode
   AST_CTRL_EMU: assert property (
      reg_rd && op_mode == MODE_EXPANDED && emulate_control_port_bit
      && reg_addr == CTRL_DATA_OFS |=> ext_req)
      else $error("control data not echoed");
   // Control direction absent in expanded mode
   AST_CTRL_DIR: assert property (
      (reg_rd || reg_wr) && op_mode == MODE_EXPANDED
      && reg_addr == CTRL_DIR_OFS |=> ext_req)
      else $error("control direction not echoed");
   // Interrupt pins are never driven
   AST_IRQ_INPUT: assert property (
      ctrl_pin_oe_n[1:0] == 2'b11)
      else $error("interrupt pin driven");
   // Interrupt pin levels pass through one flop
   AST_IRQ_COPY: assert property (
      !$past(sys_rst) |-> mask_irq_n == $past(ctrl_pin_in[1])
      && nonmaskable_interrupt_pin == $past(ctrl_pin_in[0]))
      else $error("interrupt level not passed on");
   // Interrupt pins pull up only
   AST_IRQ_PULLUP: assert property (
      !$past(sys_rst) |-> ctrl_pull_up[1:0] == 2'b11)
      else $error("interrupt pull not upward");
endmodule : port_check

bind bus_port_gpio_registers port_check u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .op_mode(op_mode),
   .emulate_control_port_bit(emulate_control_port_bit),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_req(ext_req),
   .addr_hi_pin_oe_n(addr_hi_pin_oe_n), .addr_lo_pin_oe_n(addr_lo_pin_oe_n),
   .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_oe_n(ctrl_pin_oe_n),
   .ctrl_pull_up(ctrl_pull_up), .mask_irq_n(mask_irq_n),
   .nonmaskable_interrupt_pin(nonmaskable_interrupt_pin));

/* verification/pin_partner.sv */
// Board side of one 8-bit port: loops driven pins back
module pin_partner (
   // From the port
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   // Level the board drives on released pins
   input  wire logic [7:0] board_val,
   // Back into the port
   output logic      [7:0] pin_in
);
   // Driven pins show the port's value, released ones the board's
   // Board level is always driven by the bench, so no floating bits
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & board_val);
endmodule : pin_partner

/* verification/bus_port_gpio_registers_tb.sv */
module bus_port_gpio_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bus_port_pkg::*;

   logic mclk, sys_rst, wide_bus, emu, reg_wr, reg_rd, bus_data_oe;
   logic ext_req, ext_wr, irq_n, nmi;
   logic [1:0] op_mode;
   logic [3:0] reg_addr, ext_addr;
   logic [7:0] reg_wdata, reg_rdata, ext_wdata, r;
   logic [15:0] bus_addr, bus_wdata;
   logic [7:2] alt_out, alt_oe;
   logic [7:0] hi_in, hi_out, hi_oe_n, lo_in, lo_out, lo_oe_n;
   logic [7:0] c_in, c_out, c_oe_n, pull_en, pull_up;
   logic [7:0] b_hi, b_lo, b_c;      // Board levels on released pins
   logic       e;
   int         err_count, cmp_count;

   ////////////////////////////////////////////////////////////////////////
   bus_port_gpio_registers u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .op_mode(op_mode),
      .wide_bus(wide_bus), .emulate_control_port_bit(emu),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_req(ext_req),
      .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_data_oe(bus_data_oe), .ctrl_alt_out(alt_out),
      .ctrl_alt_oe(alt_oe), .addr_hi_pin_in(hi_in),
      .addr_hi_pin_out(hi_out), .addr_hi_pin_oe_n(hi_oe_n),
      .addr_lo_pin_in(lo_in), .addr_lo_pin_out(lo_out),
      .addr_lo_pin_oe_n(lo_oe_n), .ctrl_pin_in(c_in),
      .ctrl_pin_out(c_out), .ctrl_pin_oe_n(c_oe_n),
      .ctrl_pull_en(pull_en), .ctrl_pull_up(pull_up),
      .mask_irq_n(irq_n), .nonmaskable_interrupt_pin(nmi));
   pin_partner u_hi (.pin_out(hi_out), .pin_oe_n(hi_oe_n),
                     .board_val(b_hi), .pin_in(hi_in));
   pin_partner u_lo (.pin_out(lo_out), .pin_oe_n(lo_oe_n),
                     .board_val(b_lo), .pin_in(lo_in));
   pin_partner u_c  (.pin_out(c_out), .pin_oe_n(c_oe_n),
                     .board_val(b_c), .pin_in(c_in));

   ////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One-cycle write, echo flag sampled after the answer edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1 e = ext_req;
   endtask : wr

   // One-cycle read, data stands only in the following cycle
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
      e = ext_req;
   endtask : rd

   // Pins lag registers by one edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task automatic end_of_test;
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   // Hang guard
   initial begin
      repeat (3000) @(posedge mclk);
      err_count++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, op_mode, wide_bus, emu, reg_wr, reg_rd} = 7'h40;
      {reg_addr, reg_wdata, bus_addr, bus_wdata, bus_data_oe} = '0;
      {alt_out, alt_oe} = '0;
      b_hi = 8'h3c;
      b_lo = 8'h3c;
      b_c = 8'h00;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      rd(ADDR_HI_DIR_OFS); chk(r, DIR_RST);
      rd(ADDR_LO_DIR_OFS); chk(r, DIR_RST);
      // Both address ports as general I/O, data loaded first
      for (int p = 0; p < 2; p++) begin
         wr(p ? ADDR_LO_DATA_OFS : ADDR_HI_DATA_OFS, 8'ha5);
         wr(p ? ADDR_LO_DIR_OFS : ADDR_HI_DIR_OFS, 8'hf0);
         tick(1);
         chk(p ? lo_oe_n : hi_oe_n, 8'h0f);
         chk((p ? lo_out : hi_out) & 8'hf0, 8'ha0);
         rd(p ? ADDR_LO_DATA_OFS : ADDR_HI_DATA_OFS);
         chk(r, 8'hac);
      end
      // Control port: low two pins stay inputs
      wr(CTRL_DATA_OFS, 8'hff);
      wr(CTRL_DIR_OFS, 8'hff);
      rd(CTRL_DIR_OFS); chk(r, 8'hfc);
      chk(c_oe_n, 8'h03);
      rd(CTRL_DATA_OFS); chk(r, 8'hfc);
      // Alternate function overrides direction
      wr(FUNC_SEL_OFS, 8'h04);
      tick(1);
      chk(c_oe_n, 8'h07);
      @(posedge mclk);
      alt_oe <= 6'h01;
      alt_out <= 6'h01;
      tick(2);
      chk(c_oe_n, 8'h03);
      chk(c_out & 8'h04, 8'h04);
      wr(FUNC_SEL_OFS, 8'h00);
      // One pull bit for every input
      wr(CTRL_DIR_OFS, 8'h00);
      wr(PULL_CTRL_OFS, 8'h01);
      tick(1);
      chk(pull_en, 8'hff);
      chk(pull_up, 8'hff);
      // Reserved places and a spare address
      for (int a = 4; a < 8; a++) begin
         wr(a[3:0], 8'hff);
         rd(a[3:0]); chk(r, 8'h00); chk({7'h0, e}, 8'h00);
      end
      rd(4'hf); chk(r, 8'h00);
      // Expanded mode: ports carry the bus
      @(posedge mclk);
      op_mode <= MODE_EXPANDED;
      bus_addr <= 16'h1234;
      tick(2);
      chk(hi_out, 8'h12); chk(lo_out, 8'h34);
      chk(hi_oe_n | lo_oe_n, 8'h00);
      @(posedge mclk);
      bus_data_oe <= 1'b1;
      wide_bus <= 1'b1;
      bus_wdata <= 16'habcd;
      tick(2);
      chk(hi_out, 8'hab); chk(lo_out, 8'hcd);
      @(posedge mclk);
      wide_bus <= 1'b0;
      tick(2);
      chk(hi_out, 8'hcd);
      wr(ADDR_HI_DATA_OFS, 8'h55);
      chk({7'h0, e}, 8'h01); chk(ext_wdata, 8'h55);
      chk({4'h0, ext_addr}, 8'h00);
      chk({7'h0, ext_wr}, 8'h01);
      rd(ADDR_LO_DIR_OFS); chk({7'h0, e}, 8'h01);
      chk({7'h0, ext_wr}, 8'h00);
      rd(CTRL_DATA_OFS); chk({7'h0, e}, 8'h00);
      rd(CTRL_DIR_OFS); chk({7'h0, e}, 8'h01);
      @(posedge mclk);
      emu <= 1'b1;
      rd(CTRL_DATA_OFS); chk({7'h0, e}, 8'h01);
      // Peripheral mode
      @(posedge mclk);
      op_mode <= MODE_PERIPHERAL;
      rd(4'h5); chk({7'h0, e}, 8'h01); chk(r, 8'h00);
      @(posedge mclk);
      emu <= 1'b0;
      rd(CTRL_DATA_OFS); chk({7'h0, e}, 8'h01);
      end_of_test();
   end
endmodule : bus_port_gpio_registers_tb
